// [hw/dci_controller.sv]
// Dual-CPU interrupt controller with AXI4-Lite register access
// Function
// - Sixteen external, four cross-CPU, four timers, one error
// - Inputs 1-15: low level or rising edge
// - Input 0: level or edge, either polarity
// - Cross-CPU and timer sources are event triggered
// - Registers read back; dispatch, end, reserved read zero
// - Activity flag reads live source status
// - Acknowledge read returns vector, marks in service
// - Priorities 0-15; zero never delivered
// - Task priority blocks equal or lower sources
// - In service until end write; only higher priority preempts
// - Return spurious vector when nothing valid
// - Dispatch write raises channel toward chosen CPUs
// - Repeated dispatch before acknowledge gives one interrupt
// - Reset enters pass-through: input 0 drives CPU0
// - Without pass-through input 0 uses normal routing
// - No part in legacy controller vector fetch
// - Internal errors merge into one distributed source
// - Merged error also driven on output pin
// - Divide-by-eight prescaler steps all four timers
// - Direct mode: every target above task, in-service
// - Distributed mode: exactly one eligible CPU; here the target is chosen by task alone, none if in-service blocks that CPU
// - Both eligible: lower task wins, tie CPU0
// - Selector resolves in two cycles, frozen on acknowledge
// - Masked condition stays pending until unmasked
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module dci_controller (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic [dci_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [dci_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Interrupt sources
  input wire logic [dci_pkg::NUM_EXT-1:0] extIrq,
  input wire logic [dci_pkg::NUM_ERR-1:0] errFlags,
  // Processor interrupt lines and merged error
  output logic [dci_pkg::NUM_CPU-1:0] cpuInt,
  output logic errOut
);
  import dci_pkg::*;

  dci_src_cfg_t cfg [NUM_SRC];
  dci_src_cfg_t cfgRd;
  logic [NUM_CPU-1:0] dest [NUM_SRC];
  logic passThru;
  logic [7:0] spurVec;
  logic [PRI_W-1:0] taskPri [NUM_CPU];
  logic [31:0] baseCnt [NUM_TMR];
  logic [CNT_W-1:0] curCnt [NUM_TMR];
  logic [2:0] presc;
  logic tick;
  logic errAny;
  logic [NUM_SRC-1:0] rawIn, rawPrev, lvlAct, edgeHit, edgeLatch, distPend;
  logic [NUM_SRC-1:0] srcAct;
  logic [NUM_SRC-1:0] dpend [NUM_CPU];
  logic [NUM_SRC-1:0] dirSet [NUM_CPU];
  logic [NUM_SRC-1:0] req [NUM_CPU];
  logic [NUM_SRC-1:0] ackClr [NUM_CPU];
  logic [NUM_SRC-1:0][PRI_W-1:0] allPri;
  dci_sel_t irr [NUM_CPU];
  logic [NUM_PRI-1:0] isrPri [NUM_CPU];
  logic [NUM_SRC-1:0] isrSrc [NUM_CPU];
  logic [ID_W-1:0] srcAtPri [NUM_CPU][NUM_PRI];
  logic [PRI_W-1:0] isrTop [NUM_CPU];
  logic [NUM_CPU-1:0] ackRd, eosWr, taskWr, ackOk, intNorm;
  logic [NUM_IPI-1:0] dispWr;
  logic [NUM_SRC-1:0] cfgWr, destWr;
  logic [NUM_TMR-1:0] baseWr, tmrFire;
  logic wrEn, rdEn;
  logic [ADDR_W-1:0] wA, rA;
  logic [31:0] rdNext;

  function automatic logic [ADDR_W-1:0] regAddr(
    input logic [ADDR_W-1:0] base, input logic [ADDR_W-1:0] stride,
    input int idx, input logic [ADDR_W-1:0] off);
    return ADDR_W'(base + stride * ADDR_W'(idx) + off);
  endfunction

  function automatic logic isDist(input int s);
    return (s < IPI_BASE) || (s == ERR_SRC);
  endfunction

  function automatic logic [PRI_W-1:0] topPri(input logic [NUM_PRI-1:0] b);
    topPri = '0;
    for (int p = 1; p < NUM_PRI; p++) begin
      if (b[p]) begin
        topPri = PRI_W'(p);
      end
    end
  endfunction

  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        old[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return old;
  endfunction

  // Bus handshakes: write address and data are taken together
  assign wrEn = awvalid && wvalid && !bvalid;
  assign awready = wrEn;
  assign wready = wrEn;
  assign rdEn = arvalid && !rvalid;
  assign arready = !rvalid;
  assign bresp = RESP_OKAY;
  assign rresp = RESP_OKAY;
  assign wA = {awaddr[ADDR_W-1:2], 2'h0};
  assign rA = {araddr[ADDR_W-1:2], 2'h0};

  generate
    for (genvar c = 0; c < NUM_CPU; c++) begin : g_cpuDec
      assign taskWr[c] = wrEn && wA == regAddr(CPU_BASE, CPU_STRIDE, c, NO_OFF);
      assign eosWr[c] = wrEn && wA == regAddr(CPU_BASE, CPU_STRIDE, c, EOS_OFF);
      assign ackRd[c] = rdEn && rA == regAddr(CPU_BASE, CPU_STRIDE, c, ACK_OFF);
      dci_selector u_sel (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .req(req[c]),
        .pri(allPri),
        .freeze(ackRd[c]),
        .sel(irr[c])
      );
    end
    for (genvar s = 0; s < NUM_SRC; s++) begin : g_srcDec
      assign cfgWr[s] = wrEn && wA == regAddr(SRC_BASE, SRC_STRIDE, s, NO_OFF);
      assign destWr[s] =
        wrEn && wA == regAddr(SRC_BASE, SRC_STRIDE, s, DEST_OFF);
    end
    for (genvar n = 0; n < NUM_IPI; n++) begin : g_ipiDec
      assign dispWr[n] =
        wrEn && wA == regAddr(DISP_BASE, WORD_STRIDE, n, NO_OFF);
    end
    for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmrDec
      assign baseWr[t] =
        wrEn && wA == regAddr(TMR_REG_BASE, TMR_STRIDE, t, BASECNT_OFF);
    end
  endgenerate

  // Software-written configuration
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      passThru <= 1'h1;
      spurVec <= SPUR_RST;
      for (int c = 0; c < NUM_CPU; c++) begin
        taskPri[c] <= TASK_RST;
      end
      for (int s = 0; s < NUM_SRC; s++) begin
        cfg[s] <= dci_src_cfg_t'(SRC_CFG_RST);
        dest[s] <= DEST_RST;
      end
    end else begin
      if (wrEn && wA == GCFG_ADDR && wstrb[0]) begin
        passThru <= wdata[PASS_BIT];
      end
      if (wrEn && wA == SPUR_ADDR && wstrb[0]) begin
        spurVec <= wdata[7:0];
      end
      for (int c = 0; c < NUM_CPU; c++) begin
        if (taskWr[c] && wstrb[0]) begin
          taskPri[c] <= wdata[PRI_W-1:0];
        end
      end
      for (int s = 0; s < NUM_SRC; s++) begin
        // Activity and reserved bits are never stored
        if (cfgWr[s]) begin
          cfg[s] <= dci_src_cfg_t'(mergeStrb(cfg[s], wdata, wstrb) & CFG_WMASK);
        end
        if (destWr[s] && wstrb[0]) begin
          dest[s] <= wdata[NUM_CPU-1:0];
        end
      end
    end
  end

  // Source qualification
  assign errAny = |errFlags;
  assign rawIn = {errAny, {(NUM_IPI + NUM_TMR){1'h0}}, extIrq};

  always_comb begin
    for (int s = 0; s < NUM_SRC; s++) begin
      if (s == 0 || s == ERR_SRC) begin
        lvlAct[s] = rawIn[s] == cfg[s].polarity;
        edgeHit[s] = cfg[s].polarity ? rawIn[s] && !rawPrev[s]
                                     : !rawIn[s] && rawPrev[s];
      end else begin
        // Polarity is fixed here whatever software stored
        lvlAct[s] = !rawIn[s];
        edgeHit[s] = rawIn[s] && !rawPrev[s];
      end
      distPend[s] = cfg[s].sense ? lvlAct[s] : edgeLatch[s];
      srcAct[s] = isDist(s) ? distPend[s] : dpend[0][s] || dpend[1][s];
    end
  end

  // Edge latches; a new edge in the acknowledge cycle is kept
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rawPrev <= '0;
      edgeLatch <= '0;
    end else begin
      rawPrev <= rawIn;
      for (int s = 0; s < NUM_SRC; s++) begin
        edgeLatch[s] <= isDist(s) && ((edgeLatch[s] && !ackClr[0][s]
          && !ackClr[1][s]) || (edgeHit[s] && !cfg[s].sense));
      end
    end
  end

  // Direct-mode events from dispatch writes and timer expiry
  always_comb begin
    for (int c = 0; c < NUM_CPU; c++) begin
      dirSet[c] = '0;
      for (int n = 0; n < NUM_IPI; n++) begin
        dirSet[c][IPI_BASE + n] = dispWr[n] && wdata[c];
      end
      for (int t = 0; t < NUM_TMR; t++) begin
        dirSet[c][TMR_BASE + t] = tmrFire[t] && dest[TMR_BASE + t][c];
      end
    end
  end

  // One bit per processor; repeats fold into the bit already set
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int c = 0; c < NUM_CPU; c++) begin
        dpend[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CPU; c++) begin
        dpend[c] <= (dpend[c] & ~ackClr[c]) | dirSet[c];
      end
    end
  end

  // Request qualification per processor
  always_comb begin
    for (int s = 0; s < NUM_SRC; s++) begin
      allPri[s] = cfg[s].prio;
    end
    for (int c = 0; c < NUM_CPU; c++) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        if (isDist(s)) begin
          req[c][s] = distPend[s] && dest[s][c] && !isrSrc[NUM_CPU-1-c][s]
            && !(s == 0 && passThru);
        end else begin
          req[c][s] = dpend[c][s];
        end
        req[c][s] = req[c][s] && !cfg[s].mask && cfg[s].prio != '0;
      end
    end
  end

  // Router: delivery conditions and acknowledge outcome
  always_comb begin
    for (int c = 0; c < NUM_CPU; c++) begin
      isrTop[c] = topPri(isrPri[c]);
      intNorm[c] = irr[c].valid && irr[c].pri > taskPri[c]
        && irr[c].pri > isrTop[c];
      if (isDist(int'(irr[c].id)) && (&dest[irr[c].id])) begin
        intNorm[c] = intNorm[c] && (c == 0 ? taskPri[0] <= taskPri[1]
                                           : taskPri[1] < taskPri[0]);
      end
      // A source gone or masked since selection yields the spurious vector
      ackOk[c] = intNorm[c] && req[c][irr[c].id];
      for (int s = 0; s < NUM_SRC; s++) begin
        ackClr[c][s] = ackRd[c] && ackOk[c] && irr[c].id == ID_W'(s);
      end
    end
  end

  // Legacy controller answers its own vector fetch; only its line is passed
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cpuInt <= '0;
      errOut <= 1'h0;
    end else begin
      cpuInt[0] <= passThru ? lvlAct[0] : intNorm[0];
      cpuInt[1] <= intNorm[1];
      errOut <= errAny;
    end
  end

  // In-service state; set after clear so an acknowledge beside an end wins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int c = 0; c < NUM_CPU; c++) begin
        isrPri[c] <= '0;
        isrSrc[c] <= '0;
        for (int p = 0; p < NUM_PRI; p++) begin
          srcAtPri[c][p] <= '0;
        end
      end
    end else begin
      for (int c = 0; c < NUM_CPU; c++) begin
        if (eosWr[c] && isrTop[c] != '0) begin
          isrPri[c][isrTop[c]] <= 1'h0;
          isrSrc[c][srcAtPri[c][isrTop[c]]] <= 1'h0;
        end
        if (ackRd[c] && ackOk[c]) begin
          isrPri[c][irr[c].pri] <= 1'h1;
          isrSrc[c][irr[c].id] <= 1'h1;
          srcAtPri[c][irr[c].pri] <= irr[c].id;
        end
      end
    end
  end

  // Timers
  assign tick = presc == PRESC_LAST;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      presc <= '0;
    end else begin
      presc <= tick ? '0 : 3'(presc + 3'h1);
    end
  end

  always_comb begin
    for (int t = 0; t < NUM_TMR; t++) begin
      tmrFire[t] = tick && !baseCnt[t][INHIBIT_BIT] && curCnt[t] == '0;
    end
  end

  // Writing the base count also restarts the count from it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int t = 0; t < NUM_TMR; t++) begin
        baseCnt[t] <= BASE_RST;
        curCnt[t] <= '0;
      end
    end else begin
      for (int t = 0; t < NUM_TMR; t++) begin
        if (baseWr[t]) begin
          baseCnt[t] <= mergeStrb(baseCnt[t], wdata, wstrb);
          curCnt[t] <= wdata[CNT_W-1:0];
        end else if (tick && !baseCnt[t][INHIBIT_BIT]) begin
          curCnt[t] <= tmrFire[t] ? baseCnt[t][CNT_W-1:0]
                                  : CNT_W'(curCnt[t] - 1'h1);
        end
      end
    end
  end

  // Read data; dispatch, end and unmapped words read zero
  always_comb begin
    rdNext = '0;
    cfgRd = '0;
    if (rA == GCFG_ADDR) begin
      rdNext[PASS_BIT] = passThru;
    end else if (rA == SPUR_ADDR) begin
      rdNext[7:0] = spurVec;
    end
    for (int c = 0; c < NUM_CPU; c++) begin
      if (rA == regAddr(CPU_BASE, CPU_STRIDE, c, NO_OFF)) begin
        rdNext[PRI_W-1:0] = taskPri[c];
      end else if (rA == regAddr(CPU_BASE, CPU_STRIDE, c, ACK_OFF)) begin
        rdNext[7:0] = ackOk[c] ? cfg[irr[c].id].vector : spurVec;
      end
    end
    for (int s = 0; s < NUM_SRC; s++) begin
      if (rA == regAddr(SRC_BASE, SRC_STRIDE, s, NO_OFF)) begin
        cfgRd = cfg[s];
        cfgRd.activity = srcAct[s];
        rdNext = cfgRd;
      end else if (rA == regAddr(SRC_BASE, SRC_STRIDE, s, DEST_OFF)) begin
        rdNext[NUM_CPU-1:0] = dest[s];
      end
    end
    for (int t = 0; t < NUM_TMR; t++) begin
      if (rA == regAddr(TMR_REG_BASE, TMR_STRIDE, t, NO_OFF)) begin
        rdNext[CNT_W-1:0] = curCnt[t];
      end else if (rA == regAddr(TMR_REG_BASE, TMR_STRIDE, t, BASECNT_OFF)) begin
        rdNext = baseCnt[t];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rvalid <= 1'h0;
      rdata <= '0;
    end else if (rdEn) begin
      rvalid <= 1'h1;
      rdata <= rdNext;
    end else if (rready) begin
      rvalid <= 1'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bvalid <= 1'h0;
    end else if (wrEn) begin
      bvalid <= 1'h1;
    end else if (bready) begin
      bvalid <= 1'h0;
    end
  end

  property p_passThru;
    @(posedge sys_clk) disable iff (!rst_n)
      passThru |=> cpuInt[0] == $past(lvlAct[0]);
  endproperty
  a_passThru: assert property (p_passThru) else $error("pass-through line wrong");

  property p_taskBlock;
    @(posedge sys_clk) disable iff (!rst_n)
      intNorm[1] |-> irr[1].pri > taskPri[1] && irr[1].pri != 4'h0;
  endproperty
  a_taskBlock: assert property (p_taskBlock) else $error("blocked priority");

  property p_eos;
    @(posedge sys_clk) disable iff (!rst_n)
      eosWr[0] && !ackRd[0] && isrTop[0] != 4'h0 |=>
        isrTop[0] < $past(isrTop[0]);
  endproperty
  a_eos: assert property (p_eos) else $error("end write did not retire");

  property p_spur;
    @(posedge sys_clk) disable iff (!rst_n)
      ackRd[0] && !ackOk[0] |=> rvalid && rdata[7:0] == $past(spurVec);
  endproperty
  a_spur: assert property (p_spur) else $error("spurious vector missing");

  property p_ackSet;
    @(posedge sys_clk) disable iff (!rst_n)
      ackRd[1] && ackOk[1] |=> rvalid && isrPri[1][$past(irr[1].pri)];
  endproperty
  a_ackSet: assert property (p_ackSet) else $error("not put in service");

  property p_freeze;
    @(posedge sys_clk) disable iff (!rst_n)
      ackRd[0] |=> irr[0] == $past(irr[0]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("selection moved");

  property p_ipiOnce;
    @(posedge sys_clk) disable iff (!rst_n)
      dispWr[0] && wdata[1] |=> dpend[1][IPI_BASE];
  endproperty
  a_ipiOnce: assert property (p_ipiOnce) else $error("dispatch lost");

  property p_tick;
    @(posedge sys_clk) disable iff (!rst_n)
      tick |=> !tick [*7] ##1 tick;
  endproperty
  a_tick: assert property (p_tick) else $error("prescaler not by eight");

  property p_reload;
    @(posedge sys_clk) disable iff (!rst_n)
      tmrFire[0] && !baseWr[0] |=> curCnt[0] == $past(baseCnt[0][CNT_W-1:0]);
  endproperty
  a_reload: assert property (p_reload) else $error("timer reload wrong");

  property p_errOut;
    @(posedge sys_clk) disable iff (!rst_n)
      errAny |=> errOut;
  endproperty
  a_errOut: assert property (p_errOut) else $error("error pin low");

  property p_distOne;
    @(posedge sys_clk) disable iff (!rst_n)
      intNorm[0] && intNorm[1] && irr[0].id == irr[1].id
        |-> !isDist(int'(irr[0].id));
  endproperty
  a_distOne: assert property (p_distOne) else $error("delivered twice");

endmodule

// [hw/dci_pkg.sv]
// Constants, register map and carrier types for the dual-CPU interrupt block
package dci_pkg;

  // Source population
  localparam int NUM_EXT = 16;
  localparam int NUM_IPI = 4;
  localparam int NUM_TMR = 4;
  localparam int NUM_CPU = 2;
  localparam int NUM_SRC = 25;
  localparam int IPI_BASE = 16;
  localparam int TMR_BASE = 20;
  localparam int ERR_SRC = 24;
  localparam int NUM_ERR = 4;
  localparam int ID_W = 5;
  localparam int PRI_W = 4;
  localparam int NUM_PRI = 16;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 31;

  // Timer prescaler divides the bus clock by eight
  localparam int PRESC_DIV = 8;
  localparam logic [2:0] PRESC_LAST = 3'(PRESC_DIV - 1);

  // Register byte offsets
  localparam logic [11:0] GCFG_ADDR = 12'h000;
  localparam logic [11:0] SPUR_ADDR = 12'h004;
  localparam logic [11:0] DISP_BASE = 12'h040;
  localparam logic [11:0] CPU_BASE = 12'h080;
  localparam logic [11:0] CPU_STRIDE = 12'h010;
  localparam logic [11:0] SRC_BASE = 12'h100;
  localparam logic [11:0] SRC_STRIDE = 12'h008;
  localparam logic [11:0] TMR_REG_BASE = 12'h200;
  localparam logic [11:0] TMR_STRIDE = 12'h010;
  localparam logic [11:0] WORD_STRIDE = 12'h004;
  localparam logic [11:0] NO_OFF = 12'h000;
  localparam logic [11:0] ACK_OFF = 12'h004;
  localparam logic [11:0] EOS_OFF = 12'h008;
  localparam logic [11:0] DEST_OFF = 12'h004;
  localparam logic [11:0] BASECNT_OFF = 12'h004;

  // Field positions and write masks
  localparam int PASS_BIT = 0;
  localparam int INHIBIT_BIT = 31;
  localparam logic [31:0] CFG_WMASK = 32'h80CF_00FF;

  // Reset values
  localparam logic [31:0] SRC_CFG_RST = 32'h8000_0000;
  localparam logic [31:0] BASE_RST = 32'h8000_0000;
  localparam logic [7:0] SPUR_RST = 8'hFF;
  localparam logic [3:0] TASK_RST = 4'hF;
  localparam logic [1:0] DEST_RST = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;

  // Vector-priority register of one source
  typedef struct packed {
    logic mask;
    logic activity;
    logic [5:0] rsvdHi;
    logic polarity;
    logic sense;
    logic [1:0] rsvdMid;
    logic [3:0] prio;
    logic [7:0] rsvdLo;
    logic [7:0] vector;
  } dci_src_cfg_t;

  // Selected request of one processor
  typedef struct packed {
    logic valid;
    logic [4:0] id;
    logic [3:0] pri;
  } dci_sel_t;

endpackage

// [hw/dci_selector.sv]
// Per-processor selector of the highest qualified pending request
`timescale 1ns/100ps
module dci_selector (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Qualified requests and their priorities
  input wire logic [dci_pkg::NUM_SRC-1:0] req,
  input wire logic [dci_pkg::NUM_SRC-1:0][dci_pkg::PRI_W-1:0] pri,
  // Hold the result while a vector is read
  input wire logic freeze,
  // Highest qualified request
  output dci_pkg::dci_sel_t sel
);
  import dci_pkg::*;

  dci_sel_t best;
  dci_sel_t stage;

  // Ties go to the lower source number
  always_comb begin
    best = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (req[s] && (!best.valid || pri[s] > best.pri)) begin
        best.valid = 1'h1;
        best.id = ID_W'(s);
        best.pri = pri[s];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage <= '0;
    end else begin
      stage <= best;
    end
  end

  // Frozen so the vector cannot change under an acknowledge read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sel <= '0;
    end else if (!freeze) begin
      sel <= stage;
    end
  end

endmodule

// [tb/dci_irq_src.sv]
// Model of the external interrupt request lines
`timescale 1ns/100ps
module dci_irq_src (
  // Requested activity per line
  input wire logic [15:0] act,
  input wire logic pol0,
  // Lines into the controller
  output logic [15:0] extIrq
);
  // Lines 1-15 are active low; line 0 follows its chosen polarity
  assign extIrq = {~act[15:1], pol0 ? act[0] : ~act[0]};
endmodule

// [tb/tb_top.sv]
// Register-level bench for the dual-CPU interrupt controller
`timescale 1ns/100ps
module tb_top;
  import dci_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  // Responses are always accepted, so back-to-back calls never toggle them
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1;
  logic arvalid = 1'h0, rready = 1'h1;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [3:0] wstrb = 4'hF;
  logic [3:0] errFlags = '0;
  logic awready, wready, bvalid, arready, rvalid, errOut;
  logic [1:0] bresp, rresp, cpuInt;
  logic [15:0] extIrq;
  logic [15:0] act = '0;
  logic pol0 = 1'h0;
  int err_total = 0;
  int compares = 0;

  always #50 sys_clk = ~sys_clk;

  dci_irq_src u_dci_irq_src (.act(act), .pol0(pol0), .extIrq(extIrq));

  dci_controller u_dci_controller (.sys_clk(sys_clk), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .extIrq(extIrq), .errFlags(errFlags), .cpuInt(cpuInt),
    .errOut(errOut));

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Address and data go out together; the design takes both at once
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do @(posedge sys_clk); while (!(awready && wready));
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    while (!bvalid) @(posedge sys_clk);
    chk({30'h0, bresp}, {30'h0, RESP_OKAY});
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge sys_clk); while (!rvalid);
    d = rdata;
    r = rresp;
    chk(d, e);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic waitInt(input int c, input logic e);
    int n;
    for (n = 0; n < 60 && cpuInt[c] !== e; n++) @(posedge sys_clk);
    chk({31'h0, cpuInt[c]}, {31'h0, e});
  endtask

  task automatic quiet(input logic [1:0] e);
    repeat (20) @(posedge sys_clk);
    chk({30'h0, cpuInt}, {30'h0, e});
  endtask

  task automatic note(input int n);
    $display("test %0d done", n);
  endtask

  initial begin
    repeat (6000) @(posedge sys_clk);
    err_total++;
    tally_and_finish;
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    rdc(12'h000, 32'h0000_0001);
    rdc(12'h004, 32'h0000_00FF);
    rdc(12'h080, 32'h0000_000F);
    rdc(12'h100, 32'h8000_0000);
    wr(12'h004, 32'h0000_00A5);
    rdc(12'h004, 32'h0000_00A5);
    rdc(12'h040, 32'h0000_0000);
    rdc(12'hFF0, 32'h0000_0000);
    note(1);
    act[0] <= 1'h1;
    waitInt(0, 1'h1);
    act[0] <= 1'h0;
    waitInt(0, 1'h0);
    wr(12'h000, 32'h0000_0000);
    note(2);
    // Level source 3 at priority zero must stay silent
    wr(12'h080, 32'h0000_0000);
    wr(12'h11C, 32'h0000_0001);
    wr(12'h118, 32'h0040_0033);
    act[3] <= 1'h1;
    quiet(2'h0);
    note(3);
    wr(12'h118, 32'h0045_0033);
    wr(12'h080, 32'h0000_0005);
    quiet(2'h0);
    wr(12'h080, 32'h0000_0004);
    waitInt(0, 1'h1);
    rdc(12'h118, 32'h4045_0033);
    rdc(12'h084, 32'h0000_0033);
    act[3] <= 1'h0;
    wr(12'h088, 32'h0000_0000);
    waitInt(0, 1'h0);
    rdc(12'h118, 32'h0045_0033);
    note(4);
    // Level drops before the acknowledge read
    act[3] <= 1'h1;
    waitInt(0, 1'h1);
    act[3] <= 1'h0;
    repeat (8) @(posedge sys_clk);
    rdc(12'h084, 32'h0000_00A5);
    note(5);
    // Two dispatches before acknowledge fold into one interrupt
    wr(12'h180, 32'h0007_0040);
    wr(12'h090, 32'h0000_0000);
    wr(12'h040, 32'h0000_0002);
    wr(12'h040, 32'h0000_0002);
    waitInt(1, 1'h1);
    chk({31'h0, cpuInt[0]}, 32'h0);
    rdc(12'h094, 32'h0000_0040);
    wr(12'h098, 32'h0000_0000);
    rdc(12'h094, 32'h0000_00A5);
    note(6);
    // Both targeted: equal task goes to cpu0, lower task wins
    wr(12'h11C, 32'h0000_0003);
    wr(12'h080, 32'h0000_0000);
    act[3] <= 1'h1;
    waitInt(0, 1'h1);
    chk({31'h0, cpuInt[1]}, 32'h0);
    wr(12'h080, 32'h0000_0002);
    waitInt(1, 1'h1);
    rdc(12'h094, 32'h0000_0033);
    act[3] <= 1'h0;
    wr(12'h098, 32'h0000_0000);
    note(7);
    errFlags <= 4'h4;
    repeat (3) @(posedge sys_clk);
    chk({31'h0, errOut}, 32'h1);
    errFlags <= 4'h0;
    note(8);
    // Count 3 needs four prescaler ticks of eight cycles
    wr(12'h1A0, 32'h0006_0050);
    wr(12'h1A4, 32'h0000_0001);
    wr(12'h204, 32'h0000_0003);
    quiet(2'h0);
    waitInt(0, 1'h1);
    rdc(12'h084, 32'h0000_0050);
    wr(12'h204, 32'h8000_0000);
    wr(12'h088, 32'h0000_0000);
    note(9);
    // Falling edge of input 0 from the pass-through test is still latched
    wr(12'h100, 32'h0008_0070);
    waitInt(0, 1'h1);
    rdc(12'h084, 32'h0000_0070);
    wr(12'h088, 32'h0000_0000);
    rdc(12'h100, 32'h0008_0070);
    // Input 0 as active-high edge: only the rising edge counts
    wr(12'h100, 32'h0088_0070);
    pol0 <= 1'h1;
    repeat (2) @(posedge sys_clk);
    act[0] <= 1'h1;
    waitInt(0, 1'h1);
    rdc(12'h084, 32'h0000_0070);
    wr(12'h088, 32'h0000_0000);
    act[0] <= 1'h0;
    repeat (8) @(posedge sys_clk);
    rdc(12'h084, 32'h0000_00A5);
    note(10);
    // Merged error source as active-high level toward cpu1
    wr(12'h1C4, 32'h0000_0002);
    wr(12'h1C0, 32'h00C9_0061);
    errFlags <= 4'h2;
    waitInt(1, 1'h1);
    rdc(12'h1C0, 32'h40C9_0061);
    rdc(12'h094, 32'h0000_0061);
    errFlags <= 4'h0;
    wr(12'h098, 32'h0000_0000);
    note(11);
    tally_and_finish;
  end
endmodule
